// *** rtl/arc_cfg.svh ***
// constants of the remote command controller: text codes, widths, widths of reply fields
// assumes inclusion by every module file of the block; definitions only
`ifndef ARC_CFG_SVH
`define ARC_CFG_SVH

`define ARC_CHAR_LF        8'h0A
`define ARC_CHAR_HIGH_BIT  7
`define ARC_DIGIT_BASE     8'h31
`define ARC_CMD_MAX        4'h8
`define ARC_TXT_MAX        5'h14
`define ARC_SYNC_FILL      2'h3

// command texts, right aligned in 64 bits
`define ARC_CMD_REMOTE     64'h0000_5245_4D4F_5445
`define ARC_CMD_LOCAL      64'h0000_004C_4F43_414C
`define ARC_CMD_STAGE_ON   64'h0000_414D_505F_4F4E
`define ARC_CMD_STAGE_OFF  64'h0041_4D50_5F4F_4646
`define ARC_CMD_STAGE_Q    64'h0000_0000_414D_503F
`define ARC_CMD_IDENT_Q    64'h0000_002A_4944_4E3F
`define ARC_CMD_RESET      64'h0000_0000_2A52_5354
`define ARC_CMD_CTRL_Q     64'h434F_4E54_524F_4C3F
`define ARC_CMD_FAULT_Q    64'h0053_5441_5455_533F

// reply texts, right aligned, with their lengths in bytes
`define ARC_TXT_STAGE_ON   160'h414D_505F_4F4E
`define ARC_LEN_STAGE_ON   5'h06
`define ARC_TXT_STAGE_OFF  160'h41_4D50_5F4F_4646
`define ARC_LEN_STAGE_OFF  5'h07
`define ARC_TXT_FRONT      160'h4C_4F43_414C
`define ARC_LEN_FRONT      5'h05
`define ARC_TXT_BUS        160'h4750_4942
`define ARC_LEN_BUS        5'h04
`define ARC_TXT_NET        160'h4C_414E
`define ARC_LEN_NET        5'h03
`define ARC_TXT_HARDWIRED  160'h54_544C
`define ARC_LEN_HARDWIRED  5'h03
`define ARC_TXT_HEALTHY    160'h53_5953_5445_4D5F_4F4B
`define ARC_LEN_HEALTHY    5'h09
`define ARC_TXT_SAFETY     160'h496E_7465_726C_6F63_6B20_4578_7465_726E_616C
`define ARC_LEN_SAFETY     5'h12
`define ARC_TXT_OVERHEAT   152'h5465_6D70_6572_6174_7572_6520
`define ARC_LEN_OVERHEAT   5'h0D
`define ARC_TXT_SUPPLY     152'h506F_7765_7253_7570_706C_7920
`define ARC_LEN_SUPPLY     5'h0D
`define ARC_TXT_INTERNAL   160'h43_6F6E_7472_6F6C_2046_6175_6C74
`define ARC_LEN_INTERNAL   5'h0D

// identity text, arbitrary neutral value
`define ARC_TXT_IDENT      160'h4D41_4B45_522C_4D4F_4445_4C2C_3030_3031
`define ARC_LEN_IDENT      5'h10

`endif

// *** rtl/arc_ctrl.sv ***
// remote command controller of the amplifier: line parser, hard-wired inputs, status lines
// assumes one 200 MHz clock, byte stream already extracted from the network, inputs synchronous
// except the two hard-wired command lines
`timescale 1ns/1ps
`include "arc_cfg.svh"
module arc_ctrl
    import arc_pkg::*;
#(
    parameter logic [159:0] ID_TEXT = `ARC_TXT_IDENT,
    parameter logic [4:0]   ID_LEN  = `ARC_LEN_IDENT
)
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    // network byte stream
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_valid,
    output logic [7:0]      tx_data,
    output logic            tx_valid,
    input  wire logic       tx_ready,
    output logic            cmd_drop,
    // hard-wired connector
    input  wire logic       operate_cmd_n,
    input  wire logic       takeover_cmd_n,
    output logic            supply_present_line,
    output logic            rf_output_active_line,
    output logic            hardwired_takeover_line,
    output logic            any_fault_line,
    // front panel and instrument bus side
    input  wire logic       panel_control_key,
    input  wire logic       panel_operate_key,
    input  wire logic       bus_remote_req,
    output logic [1:0]      control_point,
    // plant conditions
    input  wire logic       mains_present,
    input  wire logic       safety_loop_open,
    input  wire logic [3:0] overheat,
    input  wire logic [3:0] supply_fault,
    input  wire logic       internal_fault
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        arc_rx_state_type rx_state;
        logic [63:0]      cmd_buf;
        logic [3:0]       cmd_len;
        arc_cp_type       cp;
        logic             operating;
        arc_fault_type    flt_kind;
        logic [1:0]       flt_idx;
        logic             supply;
        logic             any_fault;
        logic             hw_line;
        logic             drop;
        logic             load;
        logic [159:0]     text;
        logic [4:0]       text_len;
    } arc_main_state_type;

    arc_main_state_type s_q;
    arc_main_state_type s_d;

    // ****************************************
    // hard-wired command edges
    // ****************************************
    logic [1:0] hw_line_n;
    logic [1:0] hw_fall;
    logic       tx_busy;

    assign hw_line_n = {takeover_cmd_n, operate_cmd_n};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_hw
            arc_edge_sync u_edge (
                .clk    (clk),
                .rst_n  (rst_n),
                .line_n (hw_line_n[g]),
                .fall   (hw_fall[g])
            );
        end
    endgenerate

    // ****************************************
    // reply serialiser
    // ****************************************
    arc_reply_tx u_tx (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (s_q.load),
        .text     (s_q.text),
        .text_len (s_q.text_len),
        .tx_ready (tx_ready),
        .busy     (tx_busy),
        .tx_data  (tx_data),
        .tx_valid (tx_valid)
    );

    // ****************************************
    // fault priority
    // ****************************************
    logic          flt_now;
    arc_fault_type flt_kind_now;
    logic [1:0]    flt_idx_now;

    always_comb begin
        flt_kind_now = ARC_FLT_NONE;
        flt_idx_now  = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (supply_fault[i]) begin
                flt_idx_now = 2'(i);
            end
        end
        if (safety_loop_open) begin
            flt_kind_now = ARC_FLT_SAFETY;
        end else if (|overheat) begin
            flt_kind_now = ARC_FLT_OVERHEAT;
            for (int i = 3; i >= 0; i--) begin
                if (overheat[i]) begin
                    flt_idx_now = 2'(i);
                end
            end
        end else if (|supply_fault) begin
            flt_kind_now = ARC_FLT_SUPPLY;
        end else if (internal_fault) begin
            flt_kind_now = ARC_FLT_INTERNAL;
        end
        flt_now = (flt_kind_now != ARC_FLT_NONE);
    end

    // ****************************************
    // command decode
    // ****************************************
    logic        line_end;
    logic        is_remote;
    logic        is_local;
    logic        is_on;
    logic        is_off;
    logic        is_stage_q;
    logic        is_ident_q;
    logic        is_reset;
    logic        is_ctrl_q;
    logic        is_fault_q;
    logic        is_query;
    logic        cp_change_ok;
    logic [7:0]  digit;

    always_comb begin
        line_end   = rx_valid && (rx_data == `ARC_CHAR_LF);
        is_remote  = (s_q.cmd_buf == `ARC_CMD_REMOTE);
        is_local   = (s_q.cmd_buf == `ARC_CMD_LOCAL);
        is_on      = (s_q.cmd_buf == `ARC_CMD_STAGE_ON);
        is_off     = (s_q.cmd_buf == `ARC_CMD_STAGE_OFF);
        is_stage_q = (s_q.cmd_buf == `ARC_CMD_STAGE_Q);
        is_ident_q = (s_q.cmd_buf == `ARC_CMD_IDENT_Q);
        is_reset   = (s_q.cmd_buf == `ARC_CMD_RESET);
        is_ctrl_q  = (s_q.cmd_buf == `ARC_CMD_CTRL_Q);
        is_fault_q = (s_q.cmd_buf == `ARC_CMD_FAULT_Q);
        is_query   = is_stage_q || is_ident_q || is_ctrl_q || is_fault_q;
        cp_change_ok = !s_q.operating;
        digit      = `ARC_DIGIT_BASE + {6'h00, s_q.flt_idx};
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d       = s_q;
        s_d.load  = 1'b0;
        s_d.drop  = 1'b0;

        // byte collection
        if (rx_valid && !line_end) begin
            if (rx_data[`ARC_CHAR_HIGH_BIT] || s_q.cmd_len == `ARC_CMD_MAX) begin
                s_d.rx_state = ARC_RX_DISCARD;
            end else begin
                s_d.cmd_buf = {s_q.cmd_buf[55:0], rx_data};
                s_d.cmd_len = s_q.cmd_len + 4'h1;
            end
        end
        if (line_end) begin
            s_d.cmd_buf  = 64'h0000_0000_0000_0000;
            s_d.cmd_len  = 4'h0;
            s_d.rx_state = ARC_RX_COLLECT;
        end

        // network commands, acted on at the terminator only
        if (line_end && s_q.rx_state == ARC_RX_COLLECT) begin
            if (is_remote && cp_change_ok) begin
                s_d.cp = ARC_CP_NET;
            end
            if (is_local && cp_change_ok) begin
                s_d.cp = ARC_CP_FRONT;
            end
            if (is_on && s_q.cp == ARC_CP_NET && !flt_now) begin
                s_d.operating = 1'b1;
            end
            if (is_off && s_q.cp == ARC_CP_NET) begin
                s_d.operating = 1'b0;
            end
            if (is_reset) begin
                s_d.flt_kind = ARC_FLT_NONE;
                s_d.flt_idx  = 2'h0;
            end
            if (is_query && (tx_busy || s_q.load)) begin
                s_d.drop = 1'b1;
            end else if (is_query) begin
                s_d.load = 1'b1;
            end
            if (!(is_remote || is_local || is_on || is_off || is_reset || is_query)) begin
                s_d.drop = 1'b1;
            end
            if (is_stage_q) begin
                s_d.text     = s_q.operating ? `ARC_TXT_STAGE_ON : `ARC_TXT_STAGE_OFF;
                s_d.text_len = s_q.operating ? `ARC_LEN_STAGE_ON : `ARC_LEN_STAGE_OFF;
            end
            if (is_ident_q) begin
                s_d.text     = ID_TEXT;
                s_d.text_len = ID_LEN;
            end
            if (is_ctrl_q) begin
                case (s_q.cp)
                    ARC_CP_FRONT: begin
                        s_d.text     = `ARC_TXT_FRONT;
                        s_d.text_len = `ARC_LEN_FRONT;
                    end
                    ARC_CP_BUS: begin
                        s_d.text     = `ARC_TXT_BUS;
                        s_d.text_len = `ARC_LEN_BUS;
                    end
                    ARC_CP_NET: begin
                        s_d.text     = `ARC_TXT_NET;
                        s_d.text_len = `ARC_LEN_NET;
                    end
                    default: begin
                        s_d.text     = `ARC_TXT_HARDWIRED;
                        s_d.text_len = `ARC_LEN_HARDWIRED;
                    end
                endcase
            end
            if (is_fault_q) begin
                case (s_q.flt_kind)
                    ARC_FLT_SAFETY: begin
                        s_d.text     = `ARC_TXT_SAFETY;
                        s_d.text_len = `ARC_LEN_SAFETY;
                    end
                    ARC_FLT_OVERHEAT: begin
                        s_d.text     = {`ARC_TXT_OVERHEAT, digit};
                        s_d.text_len = `ARC_LEN_OVERHEAT;
                    end
                    ARC_FLT_SUPPLY: begin
                        s_d.text     = {`ARC_TXT_SUPPLY, digit};
                        s_d.text_len = `ARC_LEN_SUPPLY;
                    end
                    ARC_FLT_INTERNAL: begin
                        s_d.text     = `ARC_TXT_INTERNAL;
                        s_d.text_len = `ARC_LEN_INTERNAL;
                    end
                    default: begin
                        s_d.text     = `ARC_TXT_HEALTHY;
                        s_d.text_len = `ARC_LEN_HEALTHY;
                    end
                endcase
            end
        end

        // hard-wired connector
        if (hw_fall[1] && cp_change_ok) begin
            s_d.cp = (s_q.cp == ARC_CP_HARDWIRED) ? ARC_CP_FRONT : ARC_CP_HARDWIRED;
        end
        if (hw_fall[0] && s_q.cp == ARC_CP_HARDWIRED) begin
            s_d.operating = !s_q.operating && !flt_now;
        end

        // front panel and instrument bus
        if (panel_control_key && cp_change_ok) begin
            s_d.cp = ARC_CP_FRONT;
        end
        if (panel_operate_key && s_q.cp == ARC_CP_FRONT) begin
            s_d.operating = !s_q.operating && !flt_now;
        end
        if (bus_remote_req && cp_change_ok) begin
            s_d.cp = ARC_CP_BUS;
        end

        // fault latch; a fault present in the clearing cycle wins
        if (flt_now && s_d.flt_kind == ARC_FLT_NONE) begin
            s_d.flt_kind = flt_kind_now;
            s_d.flt_idx  = flt_idx_now;
        end
        if (flt_now) begin
            s_d.operating = 1'b0;
        end

        s_d.supply    = mains_present;
        s_d.any_fault = flt_now;
        s_d.hw_line   = (s_d.cp == ARC_CP_HARDWIRED);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign supply_present_line     = s_q.supply;
    assign rf_output_active_line   = s_q.operating;
    assign hardwired_takeover_line = s_q.hw_line;
    assign any_fault_line          = s_q.any_fault;
    assign control_point           = s_q.cp;
    assign cmd_drop                = s_q.drop;

endmodule

// *** rtl/arc_edge_sync.sv ***
// synchroniser and falling-edge detector for one hard-wired command line
// assumes an asynchronous line idling high; edges are ignored until the pipe holds real samples
`timescale 1ns/1ps
`include "arc_cfg.svh"
module arc_edge_sync
    import arc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic line_n,
    output logic      fall
);

    typedef struct packed {
        logic       meta;
        logic       stable;
        logic       prev;
        logic [1:0] fill;
        logic       fall;
    } arc_edge_state_type;

    arc_edge_state_type s_q;
    arc_edge_state_type s_d;

    always_comb begin
        s_d        = s_q;
        s_d.meta   = line_n;
        s_d.stable = s_q.meta;
        s_d.prev   = s_q.stable;
        if (s_q.fill != `ARC_SYNC_FILL) begin
            s_d.fill = s_q.fill + 2'h1;
        end
        s_d.fall = (s_q.fill == `ARC_SYNC_FILL) && s_q.prev && !s_q.stable;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign fall = s_q.fall;

endmodule

// *** rtl/arc_pkg.sv ***
// types of the remote command controller
// assumes arc_cfg.svh for the numeric constants
package arc_pkg;

    typedef enum logic [1:0] {
        ARC_CP_FRONT     = 2'b00,
        ARC_CP_BUS       = 2'b01,
        ARC_CP_NET       = 2'b10,
        ARC_CP_HARDWIRED = 2'b11
    } arc_cp_type;

    typedef enum logic [2:0] {
        ARC_FLT_NONE     = 3'b000,
        ARC_FLT_SAFETY   = 3'b001,
        ARC_FLT_OVERHEAT = 3'b010,
        ARC_FLT_SUPPLY   = 3'b011,
        ARC_FLT_INTERNAL = 3'b100
    } arc_fault_type;

    typedef enum logic [0:0] {
        ARC_RX_COLLECT = 1'b0,
        ARC_RX_DISCARD = 1'b1
    } arc_rx_state_type;

    typedef enum logic [1:0] {
        ARC_TX_IDLE = 2'b00,
        ARC_TX_TEXT = 2'b01,
        ARC_TX_TERM = 2'b10
    } arc_tx_state_type;

endpackage

// *** rtl/arc_reply_tx.sv ***
// serialiser of one reply text followed by a line feed, valid/ready handshake
// assumes load only while idle; text is right aligned, first byte highest
`timescale 1ns/1ps
`include "arc_cfg.svh"
module arc_reply_tx
    import arc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [159:0] text,
    input  wire logic [4:0]   text_len,
    input  wire logic         tx_ready,
    output logic              busy,
    output logic [7:0]        tx_data,
    output logic              tx_valid
);

    typedef struct packed {
        arc_tx_state_type state;
        logic [159:0]     text;
        logic [4:0]       left;
        logic [7:0]       data;
        logic             valid;
    } arc_tx_full_type;

    arc_tx_full_type s_q;
    arc_tx_full_type s_d;

    always_comb begin
        s_d = s_q;
        case (s_q.state)
            ARC_TX_IDLE: begin
                if (load) begin
                    s_d.text  = text;
                    s_d.left  = text_len - 5'h01;
                    s_d.data  = text[{text_len - 5'h01, 3'b000} +: 8];
                    s_d.valid = 1'b1;
                    s_d.state = ARC_TX_TEXT;
                end
            end
            ARC_TX_TEXT: begin
                if (tx_ready) begin
                    if (s_q.left == 5'h00) begin
                        s_d.data  = `ARC_CHAR_LF;
                        s_d.state = ARC_TX_TERM;
                    end else begin
                        s_d.left = s_q.left - 5'h01;
                        s_d.data = s_q.text[{s_q.left - 5'h01, 3'b000} +: 8];
                    end
                end
            end
            ARC_TX_TERM: begin
                if (tx_ready) begin
                    s_d.valid = 1'b0;
                    s_d.data  = 8'h00;
                    s_d.state = ARC_TX_IDLE;
                end
            end
            default: begin
                s_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy     = (s_q.state != ARC_TX_IDLE);
    assign tx_data  = s_q.data;
    assign tx_valid = s_q.valid;

endmodule

// *** sim/arc_ctrl_asserts.sv ***
// port assertions of arc_ctrl
// assumes the bind below; one clock domain
`timescale 1ns/1ps
`include "arc_cfg.svh"
module arc_ctrl_asserts (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       cmd_drop,
    input wire logic       supply_present_line,
    input wire logic       rf_output_active_line,
    input wire logic       hardwired_takeover_line,
    input wire logic       any_fault_line,
    input wire logic [1:0] control_point,
    input wire logic       mains_present,
    input wire logic       safety_loop_open,
    input wire logic [3:0] overheat,
    input wire logic [3:0] supply_fault,
    input wire logic       internal_fault
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire flt = safety_loop_open | internal_fault | (|overheat) | (|supply_fault);
    sequence reply_end;
        tx_valid && tx_ready && tx_data == `ARC_CHAR_LF;
    endsequence
    chk_fault_summary: assert property (rst_n |=> any_fault_line == $past(flt))
        else $error("summary alarm wrong");
    chk_mains_line: assert property (rst_n |=> supply_present_line == $past(mains_present))
        else $error("mains line wrong");
    chk_hw_line: assert property (hardwired_takeover_line == (control_point == 2'b11))
        else $error("takeover line wrong");
    chk_fault_stops_stage: assert property (flt |-> ##[1:2] !rf_output_active_line)
        else $error("stage runs with fault");
    chk_cp_standby: assert property ($changed(control_point) |-> !$past(rf_output_active_line))
        else $error("control moved while operating");
    chk_reply_cause: assert property ($rose(tx_valid) |-> $past(rx_valid && rx_data == `ARC_CHAR_LF, 2))
        else $error("reply without request");
    chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte not held");
    chk_reply_close: assert property (reply_end |=> !tx_valid)
        else $error("reply runs past line feed");
    chk_drop_pulse: assert property (cmd_drop |=> !cmd_drop)
        else $error("drop pulse too long");
    chk_reset_front: assert property (disable iff (1'b0) !rst_n |-> control_point == 2'b00 && !rf_output_active_line)
        else $error("reset state wrong");
endmodule
bind arc_ctrl arc_ctrl_asserts chk_u (.clk, .rst_n, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready, .cmd_drop,
    .supply_present_line, .rf_output_active_line, .hardwired_takeover_line, .any_fault_line, .control_point,
    .mains_present, .safety_loop_open, .overheat, .supply_fault, .internal_fault);

// *** sim/arc_host_model.sv ***
// host side: takes reply bytes, prompt or slow, and collects one reply line
// assumes right aligned text, first byte highest
`timescale 1ns/1ps
`include "arc_cfg.svh"
module arc_host_model (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         slow,
    input  wire logic [7:0]   tx_data,
    input  wire logic         tx_valid,
    output logic              tx_ready,
    output logic              done,
    output logic [159:0]      reply_text,
    output logic [4:0]        reply_len
);
    logic [159:0] acc_q;
    logic [4:0]   cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {tx_ready, done, acc_q, cnt_q, reply_text, reply_len} <= '0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            done     <= 1'b0;
            if (tx_valid && tx_ready) begin
                if (tx_data == `ARC_CHAR_LF) begin
                    {done, reply_text, reply_len} <= {1'b1, acc_q, cnt_q};
                    {acc_q, cnt_q} <= '0;
                end else begin
                    acc_q <= {acc_q[151:0], tx_data};
                    cnt_q <= cnt_q + 5'h01;
                end
            end
        end
    end
endmodule

// *** sim/test_arc_ctrl.sv ***
// self-checking bench of arc_ctrl
// assumes arc_host_model on the reply side; pulses scaled down to cycles
`timescale 1ns/1ps
`include "arc_cfg.svh"
module test_arc_ctrl import arc_pkg::*;;
    logic clk, rst_n, rx_valid, tx_valid, tx_ready, cmd_drop, operate_cmd_n, takeover_cmd_n, slow, done;
    logic panel_control_key, panel_operate_key, bus_remote_req, mains_present, safety_loop_open, internal_fault;
    logic supply_present_line, rf_output_active_line, hardwired_takeover_line, any_fault_line;
    logic [7:0]   rx_data, tx_data;
    logic [3:0]   overheat, supply_fault;
    logic [1:0]   control_point;
    logic [159:0] reply_text;
    logic [4:0]   reply_len;
    int           err_count, n_compared, n_drop, k;
    logic [159:0] ft [4] = '{`ARC_TXT_SAFETY, {`ARC_TXT_OVERHEAT, 8'h33}, {`ARC_TXT_SUPPLY, 8'h31}, `ARC_TXT_INTERNAL};
    logic [4:0]   fl [4] = '{`ARC_LEN_SAFETY, `ARC_LEN_OVERHEAT, `ARC_LEN_SUPPLY, `ARC_LEN_INTERNAL};
    arc_ctrl dut_u (.clk, .rst_n, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready, .cmd_drop, .operate_cmd_n,
        .takeover_cmd_n, .supply_present_line, .rf_output_active_line, .hardwired_takeover_line, .any_fault_line,
        .panel_control_key, .panel_operate_key, .bus_remote_req, .control_point, .mains_present,
        .safety_loop_open, .overheat, .supply_fault, .internal_fault);
    arc_host_model host_u (.clk, .rst_n, .slow, .tx_data, .tx_valid, .tx_ready, .done, .reply_text, .reply_len);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) n_drop <= n_drop + int'(cmd_drop);
    // ****
    // tasks
    // ****
    task automatic print_verdict();
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [159:0] got, input logic [159:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic send(input logic [63:0] c);
        for (int i = 7; i >= -1; i--) begin
            if (i >= 0 && c[8*i+:8] == 8'h00) continue;
            rx_data  <= (i < 0) ? `ARC_CHAR_LF : c[8*i+:8];
            rx_valid <= 1'b1;
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic query(input logic [63:0] q, input logic [159:0] txt, input logic [4:0] n);
        send(q);
        for (int t = 0; t < 400 && done !== 1'b1; t++) @(posedge clk);
        if (done !== 1'b1) begin
            err_count++;
            print_verdict();
        end
        chk(reply_text, txt, "reply text");
        chk(reply_len, n, "reply length");
        @(posedge clk);
    endtask
    task automatic hit(input bit tk);
        if (tk) takeover_cmd_n <= 1'b0;
        else operate_cmd_n <= 1'b0;
        repeat (8) @(posedge clk);
        {takeover_cmd_n, operate_cmd_n} <= 2'b11;
        repeat (12) @(posedge clk);
    endtask
    // ****
    // sequence
    // ****
    initial begin
        {rst_n, rx_valid, rx_data, operate_cmd_n, takeover_cmd_n, slow, panel_control_key} = '0;
        {panel_operate_key, bus_remote_req, safety_loop_open, internal_fault, overheat, supply_fault} = '0;
        {mains_present, err_count, n_compared} = {1'b1, 64'h0};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        {takeover_cmd_n, operate_cmd_n} <= 2'b11;
        repeat (10) @(posedge clk);
        chk({control_point, rf_output_active_line}, 3'b000, "lines low at power-on");
        chk(supply_present_line, 1'b1, "mains line");
        query(`ARC_CMD_STAGE_Q, `ARC_TXT_STAGE_OFF, `ARC_LEN_STAGE_OFF);
        query(`ARC_CMD_CTRL_Q, `ARC_TXT_FRONT, `ARC_LEN_FRONT);
        slow <= 1'b1;
        query(`ARC_CMD_FAULT_Q, `ARC_TXT_HEALTHY, `ARC_LEN_HEALTHY);
        query(`ARC_CMD_IDENT_Q, `ARC_TXT_IDENT, `ARC_LEN_IDENT);
        slow <= 1'b0;
        k = n_drop;
        send(64'h0000_0041_4D50_3F0D);
        chk(n_drop, k + 1, "carriage return line");
        chk(tx_valid, 1'b0, "no reply to unknown");
        send(64'h0000_00C1_414D_503F);
        chk({n_drop, tx_valid}, {k + 1, 1'b0}, "high bit line");
        send(`ARC_CMD_REMOTE);
        query(`ARC_CMD_CTRL_Q, `ARC_TXT_NET, `ARC_LEN_NET);
        send(`ARC_CMD_STAGE_ON);
        chk(rf_output_active_line, 1'b1, "network operate");
        query(`ARC_CMD_STAGE_Q, `ARC_TXT_STAGE_ON, `ARC_LEN_STAGE_ON);
        send(`ARC_CMD_LOCAL);
        chk(control_point, ARC_CP_NET, "local refused");
        send(`ARC_CMD_STAGE_OFF);
        send(`ARC_CMD_LOCAL);
        chk(control_point, ARC_CP_FRONT, "local");
        bus_remote_req <= 1'b1;
        @(posedge clk);
        bus_remote_req <= 1'b0;
        query(`ARC_CMD_CTRL_Q, `ARC_TXT_BUS, `ARC_LEN_BUS);
        panel_control_key <= 1'b1;
        @(posedge clk);
        panel_control_key <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 2; i++) begin
            panel_operate_key <= 1'b1;
            @(posedge clk);
            panel_operate_key <= 1'b0;
            repeat (4) @(posedge clk);
            chk({control_point, rf_output_active_line}, {2'b00, i == 0}, "panel operate");
        end
        hit(1'b1);
        chk(hardwired_takeover_line, 1'b1, "takeover");
        query(`ARC_CMD_CTRL_Q, `ARC_TXT_HARDWIRED, `ARC_LEN_HARDWIRED);
        hit(1'b0);
        chk(rf_output_active_line, 1'b1, "hard-wired operate");
        hit(1'b1);
        chk(control_point, ARC_CP_HARDWIRED, "takeover refused");
        hit(1'b0);
        hit(1'b1);
        chk(control_point, ARC_CP_FRONT, "takeover back");
        for (int f = 0; f < 4; f++) begin
            panel_operate_key <= 1'b1;
            @(posedge clk);
            panel_operate_key <= 1'b0;
            {safety_loop_open, overheat[2], supply_fault[0], internal_fault} <= 4'b1000 >> f;
            repeat (3) @(posedge clk);
            chk({any_fault_line, rf_output_active_line}, 2'b10, "summary alarm");
            {safety_loop_open, overheat[2], supply_fault[0], internal_fault} <= 4'b0000;
            repeat (3) @(posedge clk);
            query(`ARC_CMD_FAULT_Q, ft[f], fl[f]);
            send(`ARC_CMD_RESET);
            query(`ARC_CMD_FAULT_Q, `ARC_TXT_HEALTHY, `ARC_LEN_HEALTHY);
        end
        print_verdict();
    end
endmodule
